// >>> hmap_pkg.sv
// hmap_pkg: shared constants and types for the host memory access port.
// assumes: one clock domain (mclk, 200 MHz), both ends compiled with this package.
package hmap_pkg;
    localparam int ADDR_W      = 27;
    localparam int DATA_W      = 32;
    localparam int BSEL_W      = 4;
    localparam int FIFO_DEPTH  = 4;
    localparam logic [3:0] STATUS_HOST_CYCLE = 4'h2;
    // memory cycle length in ns, rounded up to mclk cycles
    localparam int MEM_CYC_NS  = 20;
    localparam int CLK_NS      = 5;
    localparam int MEM_CYC_CLK = (MEM_CYC_NS + CLK_NS - 1) / CLK_NS;
    // look-ahead mode field positions and reset values
    localparam int MODE_INC_BIT = 0;
    localparam int MODE_PFW_BIT = 1;
    localparam logic [1:0] MODE_RESET = 2'h0;

    typedef enum logic [1:0] {
        HMAP_RANDOM,
        HMAP_BLOCK,
        HMAP_RMW
    } hmap_mode_t;

    function automatic hmap_mode_t hmap_decode_mode(input logic [1:0] ctl);
        if (!ctl[MODE_INC_BIT]) begin
            return HMAP_RANDOM;
        end else if (ctl[MODE_PFW_BIT]) begin
            return HMAP_RMW;
        end
        return HMAP_BLOCK;
    endfunction : hmap_decode_mode
endpackage : hmap_pkg

// >>> hmap_if.sv
// hmap_if: host-side pins between the host end and the device end.
// assumes: host strobes active low; the testbench instantiates it and drives mclk/resetn.
`timescale 1ns/1ps
interface hmap_if;
    import hmap_pkg::*;
    logic                host_chip_select_n;
    logic                host_read_strobe_n;
    logic                host_write_strobe_n;
    logic [ADDR_W-1:0]   host_longword_addr;
    logic [BSEL_W-1:0]   host_byte_selects;
    logic                host_ready;
    logic                xcvr_data_strobe;
    logic                xcvr_output_enable;
    logic [DATA_W-1:0]   xcvr_rd_data;
    logic [DATA_W-1:0]   xcvr_wr_data;

    modport device (
        input  host_chip_select_n, host_read_strobe_n, host_write_strobe_n,
        input  host_longword_addr, host_byte_selects, xcvr_wr_data,
        output host_ready, xcvr_data_strobe, xcvr_output_enable, xcvr_rd_data
    );
    modport host (
        output host_chip_select_n, host_read_strobe_n, host_write_strobe_n,
        output host_longword_addr, host_byte_selects, xcvr_wr_data,
        input  host_ready, xcvr_data_strobe, xcvr_output_enable, xcvr_rd_data
    );
endinterface : hmap_if

// >>> hmap_fifo.sv
// hmap_fifo: small flip-flop FIFO with valid/ready on both sides.
// assumes: single clock, async active-low reset.
`timescale 1ns/1ps
module hmap_fifo
    import hmap_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             resetn,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wp_q, wp_d, rp_q, rp_d;
    logic [PW:0]      cnt_q, cnt_d;
    logic             push, pop;

    assign in_ready  = (cnt_q != DEPTH[PW:0]);
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rp_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        wp_d  = push ? wp_q + 1'b1 : wp_q;
        rp_d  = pop ? rp_q + 1'b1 : rp_q;
        cnt_d = cnt_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end
endmodule : hmap_fifo

// >>> hmap_device.sv
// hmap_device: device end; acts as memory controller for host accesses.
// assumes: host pins are asynchronous (3-flop sync); local memory on plain user ports.
`timescale 1ns/1ps
module hmap_device
    import hmap_pkg::*;
(
    // clock and reset
    input  wire logic                mclk,
    input  wire logic                resetn,
    // host pins
    hmap_if.device                   hp,
    // look-ahead mode (from the host control high register)
    input  wire logic                addr_increment_enable,
    input  wire logic                prefetch_after_write_enable,
    // local memory side
    output logic                     mem_req,
    output logic                     mem_we,
    output logic [ADDR_W-1:0]        mem_addr,
    output logic [BSEL_W-1:0]        mem_cas_en,
    output logic [3:0]               local_addr_data_bus,
    output logic [DATA_W-1:0]        mem_wdata,
    input  wire logic [DATA_W-1:0]   mem_rdata,
    input  wire logic                mem_ack,
    input  wire logic                narrow_bus_width_n
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_WAIT_DIR, ST_WAIT_WDATA, ST_MEM, ST_DONE, ST_PREFETCH
    } hmap_state_t;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] cs_s_q, rd_s_q, wr_s_q;
    logic       cs_n_q, rd_n_q, wr_n_q;
    logic       cs_fall, wr_rise;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cs_s_q <= 3'h7;
            rd_s_q <= 3'h7;
            wr_s_q <= 3'h7;
            cs_n_q <= 1'b1;
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
        end else begin
            cs_s_q <= {cs_s_q[1:0], hp.host_chip_select_n};
            rd_s_q <= {rd_s_q[1:0], hp.host_read_strobe_n};
            wr_s_q <= {wr_s_q[1:0], hp.host_write_strobe_n};
            // a change counts only once the last two stages agree
            if (cs_s_q[1] == cs_s_q[2]) cs_n_q <= cs_s_q[2];
            if (rd_s_q[1] == rd_s_q[2]) rd_n_q <= rd_s_q[2];
            if (wr_s_q[1] == wr_s_q[2]) wr_n_q <= wr_s_q[2];
        end
    end

    assign cs_fall = cs_n_q && (cs_s_q[1] == cs_s_q[2]) && !cs_s_q[2];
    assign wr_rise = !wr_n_q && (wr_s_q[1] == wr_s_q[2]) && wr_s_q[2];

    // ------------------------------------------------------------
    // write data buffer
    // ------------------------------------------------------------
    logic              wf_in_valid, wf_in_ready, wf_out_valid, wf_out_ready;
    logic [DATA_W-1:0] wf_out_data;

    hmap_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_wfifo (
        .mclk      (mclk),
        .resetn    (resetn),
        .in_valid  (wf_in_valid),
        .in_ready  (wf_in_ready),
        .in_data   (hp.xcvr_wr_data),
        .out_valid (wf_out_valid),
        .out_ready (wf_out_ready),
        .out_data  (wf_out_data)
    );

    // ------------------------------------------------------------
    // access sequencer
    // ------------------------------------------------------------
    hmap_state_t       st_q, st_d;
    logic [ADDR_W-1:0] addr_q, addr_d, pf_addr_q, pf_addr_d;
    logic [BSEL_W-1:0] bs_q, bs_d;
    logic              is_rd_q, is_rd_d, pf_valid_q, pf_valid_d;
    logic              half_q, half_d, rdy_q, rdy_d, dst_q, dst_d, oe_q, oe_d;
    logic [DATA_W-1:0] rdata_q, rdata_d, pf_data_q, pf_data_d;
    hmap_mode_t        mode;

    assign mode = hmap_decode_mode({prefetch_after_write_enable, addr_increment_enable});
    // data only enters the buffer once the host has held its write to the end
    assign wf_in_valid  = wr_rise && (st_q == ST_WAIT_WDATA);
    assign wf_out_ready = (st_q == ST_MEM) && !is_rd_q && mem_ack;

    always_comb begin
        st_d       = st_q;
        addr_d     = addr_q;
        bs_d       = bs_q;
        is_rd_d    = is_rd_q;
        pf_addr_d  = pf_addr_q;
        pf_valid_d = pf_valid_q;
        pf_data_d  = pf_data_q;
        half_d     = half_q;
        rdata_d    = rdata_q;
        rdy_d      = rdy_q;
        dst_d      = 1'b0;
        oe_d       = 1'b0;
        case (st_q)
            ST_IDLE: begin
                if (cs_fall) begin
                    addr_d = hp.host_longword_addr;
                    bs_d   = hp.host_byte_selects;
                    rdy_d  = 1'b0;
                    st_d   = ST_WAIT_DIR;
                end
            end
            ST_WAIT_DIR: begin
                // direction may come before or after select
                if (!rd_n_q) begin
                    is_rd_d = 1'b1;
                    if (pf_valid_q && pf_addr_q == addr_q) begin
                        rdata_d = pf_data_q;
                        st_d    = ST_DONE;
                    end else begin
                        half_d = 1'b0;
                        st_d   = ST_MEM;
                    end
                end else if (!wr_n_q) begin
                    is_rd_d = 1'b0;
                    st_d    = ST_WAIT_WDATA;
                end else if (cs_n_q) begin
                    st_d = ST_IDLE;
                end
            end
            ST_WAIT_WDATA: begin
                if (wf_in_valid && wf_in_ready) begin
                    pf_valid_d = 1'b0; // a write may hit the prefetched word
                    st_d       = ST_MEM;
                end
            end
            ST_MEM: begin
                if (mem_ack) begin
                    if (is_rd_q && !narrow_bus_width_n && !half_q) begin
                        // first half of a 16-bit read; always run the second
                        rdata_d[15:0] = mem_rdata[15:0];
                        half_d        = 1'b1;
                    end else begin
                        if (is_rd_q && half_q) begin
                            rdata_d[31:16] = mem_rdata[15:0];
                        end else if (is_rd_q) begin
                            rdata_d = mem_rdata;
                        end
                        st_d = ST_DONE;
                    end
                end
            end
            ST_DONE: begin
                rdy_d = 1'b1;
                if (is_rd_q) begin
                    dst_d = 1'b1;
                end else begin
                    oe_d = 1'b1;
                end
                case (mode)
                    HMAP_BLOCK: begin
                        addr_d = addr_q + 1'b1;
                        st_d   = is_rd_q ? ST_PREFETCH : ST_IDLE;
                    end
                    HMAP_RMW: begin
                        addr_d = is_rd_q ? addr_q : addr_q + 1'b1;
                        st_d   = is_rd_q ? ST_IDLE : ST_PREFETCH;
                    end
                    default: begin
                        st_d = ST_IDLE;
                    end
                endcase
                if (is_rd_q && pf_valid_q && pf_addr_q == addr_q) begin
                    pf_valid_d = 1'b0;
                end
            end
            ST_PREFETCH: begin
                // next sequential longword; a select that falls before this ends is missed (cs_fall is a one-cycle pulse)
                if (mem_ack) begin
                    pf_addr_d  = addr_q;
                    pf_data_d  = mem_rdata;
                    pf_valid_d = narrow_bus_width_n;
                    st_d       = ST_IDLE;
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_q       <= ST_IDLE;
            addr_q     <= '0;
            bs_q       <= '0;
            is_rd_q    <= 1'b0;
            pf_addr_q  <= '0;
            pf_valid_q <= 1'b0;
            pf_data_q  <= '0;
            half_q     <= 1'b0;
            rdata_q    <= '0;
            // idle port shows ready, so a low ready tells the host its select was taken
            rdy_q      <= 1'b1;
            dst_q      <= 1'b0;
            oe_q       <= 1'b0;
        end else begin
            st_q       <= st_d;
            addr_q     <= addr_d;
            bs_q       <= bs_d;
            is_rd_q    <= is_rd_d;
            pf_addr_q  <= pf_addr_d;
            pf_valid_q <= pf_valid_d;
            pf_data_q  <= pf_data_d;
            half_q     <= half_d;
            rdata_q    <= rdata_d;
            rdy_q      <= rdy_d;
            dst_q      <= dst_d;
            oe_q       <= oe_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign hp.host_ready         = rdy_q;
    assign hp.xcvr_data_strobe   = dst_q;
    assign hp.xcvr_output_enable = oe_q;
    assign hp.xcvr_rd_data       = rdata_q;
    assign mem_req             = (st_q == ST_MEM) || (st_q == ST_PREFETCH);
    assign mem_we              = (st_q == ST_MEM) && !is_rd_q;
    assign mem_addr            = addr_q;
    assign mem_cas_en          = mem_we ? ~bs_q : {BSEL_W{1'b1}};
    assign mem_wdata           = wf_out_data;
    assign local_addr_data_bus = STATUS_HOST_CYCLE;
endmodule : hmap_device

// >>> hmap_host.sv
// hmap_host: host end; turns user requests into host pin cycles.
// assumes: device answers on host_ready; same mclk domain as the user.
`timescale 1ns/1ps
module hmap_host
    import hmap_pkg::*;
(
    // clock and reset
    input  wire logic                mclk,
    input  wire logic                resetn,
    // host pins
    hmap_if.host                     hp,
    // user request
    input  wire logic                req_valid,
    output logic                     req_ready,
    input  wire logic                req_write,
    input  wire logic [ADDR_W-1:0]   req_addr,
    input  wire logic [BSEL_W-1:0]   req_bsel_n,
    input  wire logic [DATA_W-1:0]   req_wdata,
    // user answer
    output logic                     rsp_valid,
    output logic [DATA_W-1:0]        rsp_rdata
);
    typedef enum logic [2:0] {
        HS_IDLE, HS_SEL, HS_WAIT_LOW, HS_WAIT_HIGH, HS_END
    } hmap_hstate_t;

    hmap_hstate_t      st_q, st_d;
    logic              cs_q, cs_d, rd_q, rd_d, wr_q, wr_d, rv_q, rv_d;
    logic              dir_wr_q, dir_wr_d;
    logic [ADDR_W-1:0] a_q, a_d;
    logic [BSEL_W-1:0] b_q, b_d;
    logic [DATA_W-1:0] wd_q, wd_d, rdat_q, rdat_d;
    logic [1:0]        rdy_s_q;
    logic              rdy_seen;

    assign req_ready = (st_q == HS_IDLE);
    assign rdy_seen  = rdy_s_q[1];

    always_comb begin
        st_d   = st_q;
        cs_d   = cs_q;
        rd_d   = rd_q;
        wr_d   = wr_q;
        a_d    = a_q;
        b_d    = b_q;
        wd_d   = wd_q;
        dir_wr_d = dir_wr_q;
        rdat_d = rdat_q;
        rv_d   = 1'b0;
        case (st_q)
            HS_IDLE: begin
                if (req_valid) begin
                    a_d  = req_addr;
                    b_d  = req_bsel_n;
                    wd_d = req_wdata;
                    // direction is kept here; the user may drop its request next cycle
                    dir_wr_d = req_write;
                    cs_d = 1'b0;
                    st_d = HS_SEL;
                end
            end
            HS_SEL: begin
                // only one direction strobe at a time
                rd_d = !dir_wr_q ? 1'b0 : 1'b1;
                wr_d = dir_wr_q ? 1'b0 : 1'b1;
                st_d = HS_WAIT_LOW;
            end
            HS_WAIT_LOW: begin
                if (!rdy_seen) begin
                    if (!wr_q) begin
                        // data is in the latch; release write to start it
                        wr_d = 1'b1;
                    end
                    st_d = HS_WAIT_HIGH;
                end
            end
            HS_WAIT_HIGH: begin
                if (rdy_seen) begin
                    rdat_d = hp.xcvr_rd_data;
                    rv_d   = rd_q == 1'b0;
                    st_d   = HS_END;
                end
            end
            HS_END: begin
                cs_d = 1'b1;
                rd_d = 1'b1;
                wr_d = 1'b1;
                st_d = HS_IDLE;
            end
            default: st_d = HS_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_q    <= HS_IDLE;
            cs_q    <= 1'b1;
            rd_q    <= 1'b1;
            wr_q    <= 1'b1;
            a_q     <= '0;
            b_q     <= 4'hF;
            wd_q    <= '0;
            dir_wr_q <= 1'b0;
            rdat_q  <= '0;
            rv_q    <= 1'b0;
            rdy_s_q <= 2'h3;
        end else begin
            st_q    <= st_d;
            cs_q    <= cs_d;
            rd_q    <= rd_d;
            wr_q    <= wr_d;
            a_q     <= a_d;
            b_q     <= b_d;
            wd_q    <= wd_d;
            dir_wr_q <= dir_wr_d;
            rdat_q  <= rdat_d;
            rv_q    <= rv_d;
            rdy_s_q <= {rdy_s_q[0], hp.host_ready};
        end
    end

    assign hp.host_chip_select_n  = cs_q;
    assign hp.host_read_strobe_n  = rd_q;
    assign hp.host_write_strobe_n = wr_q;
    assign hp.host_longword_addr  = a_q;
    assign hp.host_byte_selects   = b_q;
    assign hp.xcvr_wr_data        = wd_q;
    assign rsp_valid              = rv_q;
    assign rsp_rdata              = rdat_q;
endmodule : hmap_host

// >>> hmap_checker.sv
// hmap_checker: timing relations on the host pins between both ends.
// assumes: instantiated beside hmap_if in the bench top, single mclk domain.
`timescale 1ns/1ps
module hmap_checker
    import hmap_pkg::*;
(
    // clock and reset
    input logic              mclk,
    input logic              resetn,
    // host strobes and address
    input logic              host_chip_select_n,
    input logic              host_read_strobe_n,
    input logic              host_write_strobe_n,
    input logic [ADDR_W-1:0] host_longword_addr,
    // device answers
    input logic              host_ready,
    input logic              xcvr_data_strobe,
    input logic              xcvr_output_enable
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    sequence s_sel_fall;
        $fell(host_chip_select_n);
    endsequence
    // bound covers sync delay, the write handshake and the two memory cycles of a 16-bit read
    sequence s_ready_back;
        ##[1:80] $rose(host_ready);
    endsequence

    a_ready_returns: assert property (s_sel_fall |-> s_ready_back)
        else $error("ready not returned after select");
    a_ready_drops: assert property (s_sel_fall |-> ##[1:6] !host_ready)
        else $error("ready not lowered after select");
    a_ready_fall_sel: assert property ($fell(host_ready) |-> !host_chip_select_n)
        else $error("ready fell without select");
    a_dstb_with_ready: assert property (xcvr_data_strobe |-> $rose(host_ready))
        else $error("data strobe not at ready rise");
    a_dstb_one_pulse: assert property (xcvr_data_strobe |=> !xcvr_data_strobe)
        else $error("data strobe longer than one cycle");
    a_dstb_on_read: assert property (xcvr_data_strobe |-> host_write_strobe_n)
        else $error("data strobe during write");
    a_oe_with_ready: assert property (xcvr_output_enable |-> $rose(host_ready))
        else $error("output enable not at ready rise");
    a_oe_on_write: assert property (xcvr_output_enable |-> host_read_strobe_n)
        else $error("output enable during read");
    a_strobe_excl: assert property (host_read_strobe_n || host_write_strobe_n)
        else $error("read and write strobes both low");
    a_addr_held: assert property (!host_chip_select_n && !$past(host_chip_select_n)
        |-> $stable(host_longword_addr))
        else $error("address moved while selected");
endmodule : hmap_checker

// >>> hmap_tb_top.sv
// hmap_tb_top: host end and device end joined by hmap_if, with a memory model.
// assumes: memory answers after a few cycles; mode pins changed only when idle.
`timescale 1ns/1ps
module hmap_tb_top;
    import hmap_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic              mclk = 1'b0;
    logic              resetn = 1'b0;
    logic              req_valid = 1'b0, req_write = 1'b0, req_ready, rsp_valid;
    logic [ADDR_W-1:0] req_addr = '0, mem_addr, last_addr;
    logic [BSEL_W-1:0] req_bsel_n = 4'hF, mem_cas_en;
    logic [DATA_W-1:0] req_wdata = '0, rsp_rdata, mem_wdata, mem_rdata = '0;
    logic              inc = 1'b0, pfw = 1'b0, narrow_n = 1'b1, mem_ack = 1'b0;
    logic              mem_req, mem_we;
    logic [3:0]        status;
    logic [DATA_W-1:0] mem [16];
    logic [DATA_W-1:0] shadow [16];
    logic              odd_half = 1'b0;
    int                num_errors = 0, checks_done = 0, ack_cnt = 0, wait_cnt = 0, cycles = 0;

    always #2.5 mclk = ~mclk;

    hmap_if hp ();
    hmap_host i_hmap_host (.mclk(mclk), .resetn(resetn), .hp(hp), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
        .req_bsel_n(req_bsel_n), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata));
    hmap_device i_hmap_device (.mclk(mclk), .resetn(resetn), .hp(hp),
        .addr_increment_enable(inc), .prefetch_after_write_enable(pfw), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_cas_en(mem_cas_en),
        .local_addr_data_bus(status), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .mem_ack(mem_ack), .narrow_bus_width_n(narrow_n));
    hmap_checker i_hmap_checker (.mclk(mclk), .resetn(resetn),
        .host_chip_select_n(hp.host_chip_select_n), .host_read_strobe_n(hp.host_read_strobe_n),
        .host_write_strobe_n(hp.host_write_strobe_n), .host_longword_addr(hp.host_longword_addr),
        .host_ready(hp.host_ready), .xcvr_data_strobe(hp.xcvr_data_strobe),
        .xcvr_output_enable(hp.xcvr_output_enable));

    // ------------------------------------------------------------
    // memory model
    // ------------------------------------------------------------
    // a narrow memory gives the low half first, then the upper half on its low lanes
    always @(negedge mclk) begin
        mem_ack <= 1'b0;
        if (mem_req === 1'b1 && !mem_ack && wait_cnt == 2) begin
            mem_ack <= 1'b1;
            wait_cnt = 0;
            ack_cnt++;
            last_addr = mem_addr;
            if (mem_we === 1'b1)
                for (int b = 0; b < 4; b++)
                    if (mem_cas_en[b]) mem[mem_addr[3:0]][8*b+:8] = mem_wdata[8*b+:8];
            if (mem_we !== 1'b1 && !narrow_n && odd_half)
                mem_rdata <= {mem[mem_addr[3:0]][15:0], mem[mem_addr[3:0]][31:16]};
            else
                mem_rdata <= mem[mem_addr[3:0]];
            if (mem_we !== 1'b1 && !narrow_n) odd_half = !odd_half;
        end else begin
            if (mem_req === 1'b1 && !mem_ack) wait_cnt++;
            // released data lines do not keep the last value
            if (mem_ack) mem_rdata <= ~mem_rdata;
        end
    end

    // ------------------------------------------------------------
    // checks and user transfers
    // ------------------------------------------------------------
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk_val

    task automatic chk_cnt(input int got, input int exp);
        checks_done++;
        if (got != exp) begin
            num_errors++;
            $display("unexpected at %0t: memory cycles %0d want %0d", $time, got, exp);
        end
    endtask : chk_cnt

    // one host access; checks read data and the number of memory cycles it caused
    task automatic host_op(input logic wr, input logic [ADDR_W-1:0] a,
                           input logic [BSEL_W-1:0] bn, input logic [DATA_W-1:0] d,
                           input int acks);
        int n;
        int base;
        base = ack_cnt;
        @(negedge mclk);
        req_valid = 1'b1;
        req_write = wr;
        req_addr  = a;
        req_bsel_n = bn;
        req_wdata = d;
        n = 0;
        while (req_ready !== 1'b1 && n < 200) begin
            @(negedge mclk);
            n++;
        end
        @(negedge mclk);
        req_valid = 1'b0;
        n = 0;
        while ((wr ? hp.xcvr_output_enable : rsp_valid) !== 1'b1 && n < 200) begin
            @(negedge mclk);
            n++;
        end
        chk_cnt(n < 200 ? 0 : 1, 0);
        if (wr) begin
            for (int b = 0; b < 4; b++) begin
                if (!bn[b]) shadow[a[3:0]][8*b+:8] = d[8*b+:8];
            end
        end else begin
            chk_val(rsp_rdata, shadow[a[3:0]], "read data");
        end
        repeat (20) @(negedge mclk);
        chk_cnt(ack_cnt - base, acks);
    endtask : host_op

    task automatic results();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            results();
        end
    end

    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = 32'hC3A50000 + 32'(i);
            shadow[i] = mem[i];
        end
        repeat (20) @(negedge mclk);
        resetn = 1'b1;
        repeat (4) @(negedge mclk);
        chk_val({28'h0000000, status}, {28'h0000000, STATUS_HOST_CYCLE}, "status");
        for (int m = 0; m < 2; m++) begin
            pfw = m[0];
            host_op(1'b1, 27'h3, 4'h0, 32'h11223344, 1);
            host_op(1'b0, 27'h3, 4'h0, 32'h0, 1);
        end
        host_op(1'b1, 27'h3, 4'hA, 32'hDEADBEEF, 1);
        host_op(1'b0, 27'h3, 4'h0, 32'h0, 1);
        inc = 1'b1;
        pfw = 1'b0;
        host_op(1'b0, 27'h5, 4'h0, 32'h0, 2);
        chk_val({5'h00, last_addr}, 32'h6, "prefetch address");
        host_op(1'b0, 27'h6, 4'h0, 32'h0, 1);
        host_op(1'b1, 27'h7, 4'h0, 32'h5A5A0F0F, 1);
        host_op(1'b0, 27'h7, 4'h0, 32'h0, 2);
        pfw = 1'b1;
        host_op(1'b1, 27'h9, 4'h0, 32'h01020304, 2);
        chk_val({5'h00, last_addr}, 32'hA, "prefetch address");
        host_op(1'b0, 27'hA, 4'h0, 32'h0, 0);
        inc = 1'b0;
        narrow_n = 1'b0;
        host_op(1'b0, 27'h2, 4'h0, 32'h0, 2);
        narrow_n = 1'b1;
        results();
    end
endmodule : hmap_tb_top
